// >>> bus_master.sv
`timescale 1ns/1ps
module bus_master (
    input  wire clock,
    input  wire sda_line,
    output reg  scl_ff,
    output reg  sda_low_ff
);
    // Idle bus: clock parked high, data released
    initial begin
        scl_ff = 1'b1;
        sda_low_ff = 1'b0;
    end
    task tick(input integer n);
        repeat (n) @(posedge clock);
    endtask
    // Data moves 3 cycles into low phase, keeps hold and setup
    task bit_out(input b);
        begin
            tick(3); sda_low_ff <= !b;
            tick(3); scl_ff <= 1'b1;
            tick(6); scl_ff <= 1'b0;
        end
    endtask
    task bit_in(output b);
        begin
            tick(3); sda_low_ff <= 1'b0;
            tick(3); scl_ff <= 1'b1;
            tick(3); b = sda_line;
            tick(3); scl_ff <= 1'b0;
        end
    endtask
    task start;
        begin
            tick(3); sda_low_ff <= 1'b0;
            tick(3); scl_ff <= 1'b1;
            tick(3); sda_low_ff <= 1'b1;
            tick(3); scl_ff <= 1'b0;
        end
    endtask
    task stop;
        begin
            tick(3); sda_low_ff <= 1'b1;
            tick(3); scl_ff <= 1'b1;
            tick(3); sda_low_ff <= 1'b0;
            tick(6);
        end
    endtask
    task send(input [7:0] d, output ack);
        integer k;
        reg     nak;
        begin
            for (k = 7; k >= 0; k = k - 1) bit_out(d[k]);
            bit_in(nak);
            ack = !nak;
        end
    endtask
    // No-ack on the last byte ends a read
    task recv(output [7:0] d, input more);
        integer k;
        begin
            for (k = 7; k >= 0; k = k - 1) bit_in(d[k]);
            bit_out(!more);
        end
    endtask
endmodule

// >>> fram_array.v
`timescale 1ns/1ps
// Flip-flop byte array, one write port and one read port
module fram_array #(
    parameter DEPTH  = 8192,
    parameter ADDR_W = 13,
    parameter DATA_W = 8
) (
    input  wire              clock,
    input  wire              wr_en,
    input  wire [ADDR_W-1:0] wr_addr,
    input  wire [DATA_W-1:0] wr_data,
    input  wire [ADDR_W-1:0] rd_addr,
    output wire [DATA_W-1:0] rd_data
);
    reg [DATA_W-1:0] mem_ff [0:DEPTH-1];

    // No reset: contents persist like nonvolatile storage
    always @(posedge clock) begin
        if (wr_en) begin
            mem_ff[wr_addr] <= wr_data;
        end
    end

    assign rd_data = mem_ff[rd_addr];
endmodule

// >>> fram_slave_map.vh
`ifndef FRAM_SLAVE_MAP_VH
`define FRAM_SLAVE_MAP_VH

// Array geometry
`define ADDR_W          13
`define DATA_W          8
`define MEM_DEPTH       8192
// Slave address byte fields
`define SADDR_TYPE_MSB  7
`define SADDR_TYPE_LSB  4
`define SADDR_SEL_MSB   3
`define SADDR_SEL_LSB   1
`define SADDR_RW_BIT    0
// Arbitrary device-type code, override per product
`define DEV_TYPE_CODE   4'h5
// Bits per byte on the wire
`define BITS_PER_BYTE   4'h8
// Reset values
`define ADDR_RST        13'h0000
`define SHIFT_RST       8'h00

`endif

// >>> i2c_fram_slave_memory.v
`timescale 1ns/1ps
`include "fram_slave_map.vh"

// Function
// [RULE_01] Answer only when the received select bits match the straps.
// [RULE_02] Sample data at serial clock rise, change output at its fall.
// [RULE_03] Write-protect high blocks every write, low allows every write.
// [RULE_04] Unconnected select straps read low (pull-down, outside).
// [RULE_05] Unconnected write-protect reads low, so the part is writable.
// [RULE_06] The array holds 8192 bytes, each picked by a 13-bit address.
// [RULE_07] Two address bytes follow the slave address; top 3 bits ignored.
// [RULE_08] Each received data byte is committed at once, no stall.
// [RULE_09] A write is done before any following transaction can start.
// [RULE_10] Data line is only pulled low or released, never driven high.
// [RULE_11] First byte holds type code 7:4, select 3:1, read flag in bit 0.
// [RULE_12] Address latch increments after each data byte, wrapping to 0.
// [RULE_13] Reads continue on master ack and end on master no-ack.
// [RULE_14] Memory updates only after the 8th bit; start/stop aborts.
// [RULE_15] Under protection, data is acked and address advances, no write.
// [RULE_16] Master sends high address byte first, each byte MSB first.
module i2c_fram_slave_memory #(
    parameter ADDR_W = `ADDR_W,
    parameter DATA_W = `DATA_W,
    parameter DEPTH  = `MEM_DEPTH
) (
    input  wire       clock,
    input  wire       rst_b,
    input  wire       scl_in,
    input  wire       sda_in,
    output wire       sda_out,
    output wire       sda_oe,
    input  wire [2:0] select_strap_inputs,
    input  wire       write_protect
);
    // One-hot protocol states
    localparam [5:0] ST_IDLE  = 6'h01;
    localparam [5:0] ST_SADDR = 6'h02;
    localparam [5:0] ST_ADRHI = 6'h04;
    localparam [5:0] ST_ADRLO = 6'h08;
    localparam [5:0] ST_WDATA = 6'h10;
    localparam [5:0] ST_RDATA = 6'h20;

    // Two-stage synchronisers for every outside input except clock and rst_b
    reg [1:0] scl_sync_ff;
    reg [1:0] sda_sync_ff;
    reg [1:0] sel0_sync_ff;
    reg [1:0] sel1_sync_ff;
    reg [1:0] sel2_sync_ff;
    reg [1:0] wp_sync_ff;
    reg       scl_prev_ff;
    reg       sda_prev_ff;

    reg [5:0]        state_ff;
    reg [5:0]        nxt_state;
    reg [3:0]        bit_cnt_ff;
    reg [DATA_W-1:0] shift_ff;
    reg              ack_phase_ff;
    reg              drive_low_ff;
    reg [ADDR_W-1:0] addr_ff;
    reg [4:0]        addr_hi_ff;
    reg              mem_we_ff;
    reg [ADDR_W-1:0] mem_waddr_ff;
    reg [DATA_W-1:0] mem_wdata_ff;
    reg              rd_ack_ok_ff;
    reg              rx_last_ff;
    reg              rd_tx_bit;
    reg [DATA_W-1:0] tx_byte_ff;

    wire [DATA_W-1:0] rd_data;
    wire [2:0]        sel_sync;
    wire              scl_s;
    wire              sda_s;
    wire              wp_s;
    wire              scl_rise;
    wire              scl_fall;
    wire              start_cond;
    wire              stop_cond;
    wire              byte_done;
    wire [DATA_W-1:0] rx_byte;
    wire              sel_match;

    // Synchroniser chains; first stage feeds only the second
    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            scl_sync_ff  <= 2'h3;
            sda_sync_ff  <= 2'h3;
            sel0_sync_ff <= 2'h0;
            sel1_sync_ff <= 2'h0;
            sel2_sync_ff <= 2'h0;
            wp_sync_ff   <= 2'h0;
            scl_prev_ff  <= 1'b1;
            sda_prev_ff  <= 1'b1;
        end else begin
            scl_sync_ff  <= {scl_sync_ff[0], scl_in};
            sda_sync_ff  <= {sda_sync_ff[0], sda_in};
            sel0_sync_ff <= {sel0_sync_ff[0], select_strap_inputs[0]};
            sel1_sync_ff <= {sel1_sync_ff[0], select_strap_inputs[1]};
            sel2_sync_ff <= {sel2_sync_ff[0], select_strap_inputs[2]};
            wp_sync_ff   <= {wp_sync_ff[0], write_protect};
            scl_prev_ff  <= scl_sync_ff[1];
            sda_prev_ff  <= sda_sync_ff[1];
        end
    end

    // Pull-downs sit in the pad; an open strap arrives here as 0
    assign sel_sync = {sel2_sync_ff[1], sel1_sync_ff[1],
                       sel0_sync_ff[1]};                    // [RULE_04]
    assign wp_s     = wp_sync_ff[1];                        // [RULE_05]
    assign scl_s    = scl_sync_ff[1];
    assign sda_s    = sda_sync_ff[1];

    // Edge and bus condition detection on the sampled pins
    assign scl_rise   = scl_s & ~scl_prev_ff;               // [RULE_02]
    assign scl_fall   = ~scl_s & scl_prev_ff;               // [RULE_02]
    assign start_cond = scl_s & scl_prev_ff & sda_prev_ff & ~sda_s;
    assign stop_cond  = scl_s & scl_prev_ff & ~sda_prev_ff & sda_s;

    // Eighth bit arrives at this rise; shift_ff holds the first seven
    assign byte_done = scl_rise & ~ack_phase_ff &
                       (bit_cnt_ff == (`BITS_PER_BYTE - 4'h1));
    assign rx_byte   = {shift_ff[DATA_W-2:0], sda_s};       // [RULE_16]

    // Type code and straps must both match
    assign sel_match = (rx_byte[`SADDR_TYPE_MSB:`SADDR_TYPE_LSB] ==
                        `DEV_TYPE_CODE) &&                  // [RULE_11]
                       (rx_byte[`SADDR_SEL_MSB:`SADDR_SEL_LSB] ==
                        sel_sync);                          // [RULE_01]

    // Next protocol state
    always @* begin
        nxt_state = state_ff;
        case (state_ff)
            ST_IDLE: begin
                nxt_state = ST_IDLE;
            end
            ST_SADDR: begin
                if (byte_done) begin
                    if (!sel_match) begin
                        nxt_state = ST_IDLE;                // [RULE_01]
                    end else if (rx_byte[`SADDR_RW_BIT]) begin
                        nxt_state = ST_RDATA;               // [RULE_11]
                    end else begin
                        nxt_state = ST_ADRHI;               // [RULE_07]
                    end
                end
            end
            ST_ADRHI: begin
                if (byte_done) begin
                    nxt_state = ST_ADRLO;                   // [RULE_16]
                end
            end
            ST_ADRLO: begin
                if (byte_done) begin
                    nxt_state = ST_WDATA;
                end
            end
            ST_WDATA: begin
                nxt_state = ST_WDATA;
            end
            ST_RDATA: begin
                // Master no-ack ends the read
                if (ack_phase_ff && scl_rise && sda_s) begin
                    nxt_state = ST_IDLE;                    // [RULE_13]
                end
            end
            default: begin
                nxt_state = ST_IDLE;
            end
        endcase
        // Start always re-arms; stop always drops out
        if (start_cond) begin
            nxt_state = ST_SADDR;                           // [RULE_14]
        end else if (stop_cond) begin
            nxt_state = ST_IDLE;                            // [RULE_14]
        end
    end

    // Bit counter, shifter, ack phase and data line drive
    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            state_ff     <= ST_IDLE;
            bit_cnt_ff   <= 4'h0;
            shift_ff     <= `SHIFT_RST;
            ack_phase_ff <= 1'b0;
            drive_low_ff <= 1'b0;
            rd_ack_ok_ff <= 1'b0;
            rx_last_ff   <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            if (start_cond || stop_cond) begin
                // Abort: partial byte is dropped, nothing written
                bit_cnt_ff   <= 4'h0;
                ack_phase_ff <= 1'b0;
                drive_low_ff <= 1'b0;
                rd_ack_ok_ff <= 1'b0;
            end else if (state_ff == ST_IDLE) begin
                bit_cnt_ff   <= 4'h0;
                ack_phase_ff <= 1'b0;
                drive_low_ff <= 1'b0;
            end else if (scl_rise) begin
                if (ack_phase_ff) begin
                    bit_cnt_ff   <= 4'h0;
                    rd_ack_ok_ff <= ~sda_s;                 // [RULE_13]
                end else begin
                    shift_ff   <= rx_byte;                  // [RULE_02]
                    bit_cnt_ff <= bit_cnt_ff + 4'h1;
                    // Receiver owes the ack, incl. read slave address
                    rx_last_ff <= (state_ff != ST_RDATA);
                end
            end else if (scl_fall) begin
                if (bit_cnt_ff == `BITS_PER_BYTE && !ack_phase_ff) begin
                    // Enter ack slot; we ack what we received
                    ack_phase_ff <= 1'b1;
                    drive_low_ff <= rx_last_ff &&
                                    (state_ff != ST_IDLE);
                end else if (ack_phase_ff) begin
                    ack_phase_ff <= 1'b0;
                    drive_low_ff <= (state_ff == ST_RDATA) &&
                                    rd_ack_ok_ff &&
                                    ~rd_data[DATA_W-1];     // [RULE_02]
                    if (state_ff == ST_RDATA) begin
                        shift_ff <= rd_data;
                    end
                end else if (state_ff == ST_RDATA) begin
                    // Next read bit goes out on the falling edge
                    drive_low_ff <= ~rd_tx_bit;             // [RULE_02]
                end
            end
        end
    end

    // Transmit bit under the read pointer of the loaded byte
    always @* begin
        rd_tx_bit = 1'b1;
        if (bit_cnt_ff < `BITS_PER_BYTE) begin
            rd_tx_bit = tx_byte_ff[DATA_W-1 - bit_cnt_ff[2:0]];
        end
    end

    // Byte being sent, loaded at the start of each read byte
    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            tx_byte_ff <= `SHIFT_RST;
        end else if (scl_fall && ack_phase_ff) begin
            tx_byte_ff <= rd_data;
        end else if (scl_fall && bit_cnt_ff == 4'h0 &&
                     state_ff == ST_SADDR) begin
            tx_byte_ff <= rd_data;
        end
    end

    // Address latch, array write strobe
    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            addr_ff      <= `ADDR_RST;
            addr_hi_ff   <= 5'h00;
            mem_we_ff    <= 1'b0;
            mem_waddr_ff <= `ADDR_RST;
            mem_wdata_ff <= `SHIFT_RST;
        end else begin
            mem_we_ff <= 1'b0;
            if (byte_done && !start_cond && !stop_cond) begin
                case (state_ff)
                    ST_ADRHI: begin
                        // Top three bits of the high byte dropped
                        addr_hi_ff <= rx_byte[4:0];         // [RULE_07]
                    end
                    ST_ADRLO: begin
                        addr_ff <= {addr_hi_ff, rx_byte};   // [RULE_06]
                    end
                    ST_WDATA: begin
                        // Commit at the 8th bit, before the ack
                        mem_we_ff    <= ~wp_s;   // [RULE_03] [RULE_15]
                        mem_waddr_ff <= addr_ff;            // [RULE_08]
                        mem_wdata_ff <= rx_byte;            // [RULE_14]
                        addr_ff      <= addr_ff + 1'b1;     // [RULE_12]
                    end
                    ST_RDATA: begin
                        // Read byte fully sent; point at the next one
                        addr_ff <= addr_ff + 1'b1;          // [RULE_12]
                    end
                    default: begin
                        addr_ff <= addr_ff;
                    end
                endcase
            end
        end
    end

    // Write lands two clocks after the 8th rise, long before any
    // new start could be seen on the bus
    fram_array #(
        .DEPTH  (DEPTH),
        .ADDR_W (ADDR_W),
        .DATA_W (DATA_W)
    ) u_array (
        .clock   (clock),
        .wr_en   (mem_we_ff),                               // [RULE_09]
        .wr_addr (mem_waddr_ff),
        .wr_data (mem_wdata_ff),
        .rd_addr (addr_ff),
        .rd_data (rd_data)
    );

    // Open drain: output is always 0, only the enable moves
    assign sda_out = 1'b0;                                  // [RULE_10]
    assign sda_oe  = drive_low_ff;                          // [RULE_10]
endmodule

// >>> i2c_fram_slave_memory_sva.sv
`timescale 1ns/1ps
`include "fram_slave_map.vh"
module i2c_fram_slave_memory_chk (
    input wire       clock,
    input wire       rst_b,
    input wire       scl_in,
    input wire       sda_in,
    input wire       sda_out,
    input wire       sda_oe,
    input wire [2:0] select_strap_inputs,
    input wire       write_protect
);
    reg  [3:0] cnt_ff;
    reg  [6:0] sh_ff;
    reg        first_ff, miss_ff, hit_ff, scl_d_ff, sda_d_ff;
    wire       start_ev = scl_in && scl_d_ff && sda_d_ff && !sda_in;
    wire       stop_ev  = scl_in && scl_d_ff && !sda_d_ff && sda_in;
    wire       rise_ev  = scl_in && !scl_d_ff;
    wire [7:0] byte_w   = {sh_ff, sda_in};
    wire       match    = byte_w[7:4] == `DEV_TYPE_CODE &&
                          byte_w[3:1] == select_strap_inputs;
    // Shadow decode of the first byte after each start
    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            cnt_ff <= 4'h0; sh_ff <= 7'h00; first_ff <= 1'b0;
            miss_ff <= 1'b0; hit_ff <= 1'b0;
            scl_d_ff <= 1'b1; sda_d_ff <= 1'b1;
        end else begin
            scl_d_ff <= scl_in;
            sda_d_ff <= sda_in;
            hit_ff <= 1'b0;
            if (start_ev) begin
                cnt_ff <= 4'h0; first_ff <= 1'b1; miss_ff <= 1'b0;
            end else if (rise_ev) begin
                sh_ff <= byte_w[6:0];
                if (cnt_ff != 4'hf) cnt_ff <= cnt_ff + 4'h1;
                if (first_ff && cnt_ff == 4'h7) begin
                    first_ff <= 1'b0;
                    miss_ff <= !match;
                    hit_ff <= match;
                end
            end
        end
    end
    default clocking dc @(posedge clock); endclocking
    default disable iff (!rst_b);
    od_low_a: assert property (sda_out == 1'b0)
        else $error("data line driven high");
    oe_scl_low_a: assert property ($changed(sda_oe) |-> !scl_in)
        else $error("output changed with clock high");
    oe_hold_a: assert property (
        $rose(scl_in) |-> ##1 $stable(sda_oe)[*3])
        else $error("output moved during clock high");
    start_free_a: assert property (start_ev |-> !sda_oe)
        else $error("line held at start");
    stop_free_a: assert property (stop_ev |-> !sda_oe)
        else $error("line held at stop");
    ack_hold_a: assert property (
        $rose(sda_oe) |-> sda_oe throughout (##[1:40] $rose(scl_in)))
        else $error("drive dropped early");
    sel_miss_a: assert property (miss_ff |-> !sda_oe)
        else $error("answered a foreign address");
    sel_hit_a: assert property (hit_ff |-> ##[1:40] sda_oe)
        else $error("own address not acknowledged");
    rst_quiet_a: assert property ($rose(rst_b) |-> (!sda_oe)[*3])
        else $error("drive right after reset");
    cover property (hit_ff);
    cover property ($rose(miss_ff));
    cover property (stop_ev);
endmodule
bind i2c_fram_slave_memory i2c_fram_slave_memory_chk chk_inst (
    .clock(clock), .rst_b(rst_b), .scl_in(scl_in), .sda_in(sda_in),
    .sda_out(sda_out), .sda_oe(sda_oe),
    .select_strap_inputs(select_strap_inputs),
    .write_protect(write_protect));

// >>> i2c_fram_slave_memory_test.sv
`timescale 1ns/1ps
`include "fram_slave_map.vh"
module i2c_fram_slave_memory_test;
    reg         clock = 1'b0;
    reg         rst_b = 1'b0;
    reg  [2:0]  select_strap_inputs = 3'h0;
    reg         write_protect = 1'b0;
    wire        scl, m_low, sda_out, sda_oe;
    integer     fails = 0, checked = 0, i;
    reg         a, rwp;
    reg  [15:0] got;
    reg  [29:0] rows [0:4];
    reg  [12:0] ra;
    reg  [7:0]  rdat, rexp;
    // Open-drain line, pull-up gives the high level
    wire sda = !((sda_oe && !sda_out) || m_low);
    always #2 clock = ~clock;
    i2c_fram_slave_memory i2c_fram_slave_memory_inst (.clock(clock),
        .rst_b(rst_b), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
        .sda_oe(sda_oe), .select_strap_inputs(select_strap_inputs),
        .write_protect(write_protect));
    bus_master bus_master_inst (.clock(clock), .sda_line(sda),
        .scl_ff(scl), .sda_low_ff(m_low));
    task check(input [15:0] seen, input [15:0] exp);
        begin
            checked = checked + 1;
            if (seen !== exp) begin
                fails = fails + 1;
                $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
            end
        end
    endtask
    task tx(input [7:0] b);
        begin
            bus_master_inst.send(b, a);
            check(a, 16'h0001);
        end
    endtask
    task sa(input rw);
        begin
            bus_master_inst.start;
            tx({`DEV_TYPE_CODE, select_strap_inputs, rw});
        end
    endtask
    // Upper three address bits sent as ones, must be ignored
    task set_addr(input [12:0] ad);
        begin
            sa(1'b0);
            tx({3'b111, ad[12:8]});
            tx(ad[7:0]);
        end
    endtask
    task wr(input [12:0] ad, input [15:0] d, input integer n);
        begin
            set_addr(ad);
            if (n == 2) tx(d[15:8]);
            tx(d[7:0]);
            bus_master_inst.stop;
        end
    endtask
    task rd(input cur, input [12:0] ad, input integer n, output [15:0] q);
        begin
            q = 16'h0000;
            if (!cur) set_addr(ad);
            sa(1'b1);
            if (n == 2) bus_master_inst.recv(q[15:8], 1'b1);
            bus_master_inst.recv(q[7:0], 1'b0);
            bus_master_inst.stop;
        end
    endtask
    task test_done;
        begin
            $display("checked=%0d fails=%0d", checked, fails);
            if (fails == 0 && checked > 0)
                $display("ALL CHECKS OK");
            else
                $display("CHECKS NOT OK");
            $finish;
        end
    endtask
    // Bound well above the expected run of about 14k cycles
    initial begin
        repeat (60000) @(posedge clock);
        fails = fails + 1;
        test_done;
    end
    initial begin
        rows[0] = {13'h0000, 1'b0, 8'h5a, 8'h5a};
        rows[1] = {13'h1fff, 1'b0, 8'ha5, 8'ha5};
        rows[2] = {13'h0123, 1'b0, 8'h3c, 8'h3c};
        rows[3] = {13'h0123, 1'b1, 8'hff, 8'h3c};
        rows[4] = {13'h0124, 1'b0, 8'h00, 8'h00};
        repeat (10) @(posedge clock);
        check(sda_oe, 16'h0000);
        rst_b <= 1'b1;
        repeat (3) @(posedge clock);
        // Every strap value, matching and mismatching select
        for (i = 0; i < 16; i = i + 1) begin
            select_strap_inputs <= i[2:0];
            @(posedge clock);
            bus_master_inst.start;
            bus_master_inst.send({`DEV_TYPE_CODE, i[2:0] ^ {i[3], 2'b00},
                1'b0}, a);
            bus_master_inst.stop;
            check(a, !i[3]);
        end
        bus_master_inst.start;
        bus_master_inst.send({~`DEV_TYPE_CODE, select_strap_inputs, 1'b0}, a);
        bus_master_inst.stop;
        check(a, 16'h0000);
        $display("select test done");
        for (i = 0; i < 5; i = i + 1) begin
            {ra, rwp, rdat, rexp} = rows[i];
            write_protect <= rwp;
            wr(ra, {8'h00, rdat}, 1);
            write_protect <= 1'b0;
            rd(1'b0, ra, 1, got);
            check(got, {8'h00, rexp});
            $display("row %0d done", i);
        end
        // Protected burst: acked, address moves, array kept
        write_protect <= 1'b1;
        wr(13'h0122, 16'h7777, 2);
        write_protect <= 1'b0;
        rd(1'b1, 13'h0000, 1, got);
        check(got, 16'h0000);
        rd(1'b0, 13'h0123, 1, got);
        check(got, 16'h003c);
        $display("protect test done");
        wr(13'h1fff, 16'h1122, 2);
        rd(1'b0, 13'h1fff, 2, got);
        check(got, 16'h1122);
        rd(1'b0, 13'h0000, 1, got);
        check(got, 16'h0022);
        $display("wrap test done");
        // Half a data byte, then start (i=0) or stop (i=1)
        for (i = 0; i < 2; i = i + 1) begin
            set_addr(13'h0123);
            repeat (4) bus_master_inst.bit_out(1'b1);
            if (i == 1) bus_master_inst.stop;
            rd(1'b0, 13'h0123, 1, got);
            check(got, 16'h003c);
        end
        $display("abort test done");
        // Reset in mid-byte: latch back to 0, array contents kept
        set_addr(13'h0123);
        repeat (2) bus_master_inst.bit_out(1'b1);
        rst_b <= 1'b0;
        repeat (10) @(posedge clock);
        check(sda_oe, 16'h0000);
        rst_b <= 1'b1;
        repeat (3) @(posedge clock);
        rd(1'b1, 13'h0000, 1, got);
        check(got, 16'h0022);
        rd(1'b0, 13'h0123, 1, got);
        check(got, 16'h003c);
        $display("reset test done");
        test_done;
    end
endmodule
